// ==== src/pmt_pkg.sv ====
package pmt_pkg;
   // ------------------------------------------------------------
   // Register map (APB byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_TICK_COUNT = 8'h00;
   localparam logic [7:0] ADDR_MATCH_PERIOD = 8'h04;
   localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h08;
   localparam logic [7:0] ADDR_FLAG = 8'h0c;
   localparam logic [7:0] ADDR_ENABLE = 8'h10;
   localparam logic [7:0] ADDR_GLOBAL = 8'h14;
   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int CTL_ON_BIT = 2;
   localparam int CTL_PRE_LSB = 0;
   localparam int CTL_POST_LSB = 3;
   localparam int FLAG_MATCH_BIT = 1;
   localparam int EN_MATCH_BIT = 1;
   localparam int GLB_PERIPH_BIT = 6;
   localparam logic [7:0] TICK_RESET = 8'h00;
   localparam logic [7:0] PERIOD_RESET = 8'hff;
   localparam logic [6:0] CTL_RESET = 7'h00;
   // ------------------------------------------------------------
   // Timing: instruction clock is the system clock divided by four
   // ------------------------------------------------------------
   localparam int INSTR_DIV = 4;
   localparam logic [1:0] PRE_DIV1 = 2'h0;
   localparam logic [1:0] PRE_DIV4 = 2'h1;
   localparam logic [3:0] PRE_LAST4 = 4'h3;
   localparam logic [3:0] PRE_LAST16 = 4'hf;

   typedef struct packed {
      logic [7:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } pmt_apb_req_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } pmt_apb_rsp_type;
endpackage

// ==== src/pmt_div_counter.sv ====
`timescale 1ns/10ps
`default_nettype none
module pmt_div_counter #(
   parameter int WIDTH = 4
) (
   input wire logic i_clk,
   input wire logic i_clear,
   input wire logic i_step,
   input wire logic [WIDTH-1:0] i_last,
   output logic o_done
);
   typedef struct packed {
      logic [WIDTH-1:0] cnt;
   } pmt_div_state_type;
   pmt_div_state_type st_reg;
   pmt_div_state_type st_next;

   always_comb begin
      st_next = st_reg;
      o_done = 1'b0;
      if (i_clear) begin
         st_next.cnt = '0;
      end else if (i_step) begin
         if (st_reg.cnt >= i_last) begin
            st_next.cnt = '0;
            o_done = 1'b1;
         end else begin
            st_next.cnt = st_reg.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      st_reg <= st_next;
   end
endmodule
`default_nettype wire

// ==== src/pmt_timer.sv ====
`timescale 1ns/10ps
`default_nettype none
// Function
// R1 - The instruction clock (system clock over four) feeds a prescaler of 1, 4 or 16.
// R2 - Each prescaler output pulse increments the 8-bit tick_count by one.
// R3 - tick_count counts up from zero and is compared with match_period all the time.
// R4 - After a match tick_count returns to zero on the next increment instead of passing it.
// R5 - Each match advances a postscaler programmable from 1 to 16.
// R6 - Each postscaler completion sets match_flag.
// R7 - tick_count and match_period are fully readable and writable 8-bit registers.
// R8 - Reset loads tick_count with zero and match_period with all ones.
// R9 - Counting runs while timer_on is one and stops while it is zero.
// R10 - prescale_select and postscale_select in timer_control choose the ratios.
// R11 - Prescaler and postscaler are cleared by a write to tick_count or timer_control and reset.
// R12 - A write to timer_control leaves tick_count unchanged.
// R13 - match_flag raises the interrupt only while match_irq_enable (bit 1) is set.
// R14 - periph_irq_enable must also be set for the interrupt to be delivered.
// R15 - prescale_select 00 is 1, 01 is 4, 1x is 16; postscale_select n divides by n plus one.
// R16 - match_flag stays set until software clears it, extra completions keep it set.
module pmt_timer (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire pmt_pkg::pmt_apb_req_type i_apb,
   output var pmt_pkg::pmt_apb_rsp_type o_apb,
   output logic o_irq,
   output logic o_match_pulse
);
   import pmt_pkg::*;

   typedef struct packed {
      logic [7:0] tick_count;
      logic [7:0] match_period;
      logic [6:0] timer_control;
      logic match_flag;
      logic match_irq_enable;
      logic periph_irq_enable;
      logic [1:0] instr_div;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq;
      logic match_pulse;
   } pmt_state_type;

   pmt_state_type st_reg;
   pmt_state_type st_next;

   logic wr_access;
   logic rd_access;
   logic instr_tick;
   logic pre_done;
   logic post_done;
   logic scaler_clear;
   logic timer_on;
   logic [1:0] prescale_select;
   logic [3:0] postscale_select;
   logic [3:0] pre_last;
   logic at_match;

   // ------------------------------------------------------------
   // Control decode
   // ------------------------------------------------------------
   // Access phase takes two cycles: pready is registered and goes high in the second access cycle
   assign wr_access = i_apb.psel && i_apb.penable && i_apb.pwrite && !st_reg.pready;
   assign rd_access = i_apb.psel && i_apb.penable && !i_apb.pwrite && !st_reg.pready;
   assign timer_on = st_reg.timer_control[CTL_ON_BIT]; // R9
   assign prescale_select = st_reg.timer_control[CTL_PRE_LSB +: 2];
   assign postscale_select = st_reg.timer_control[CTL_POST_LSB +: 4];
   assign instr_tick = timer_on && (st_reg.instr_div == 2'(INSTR_DIV - 1)); // R1
   assign at_match = (st_reg.tick_count == st_reg.match_period); // R3
   assign scaler_clear = i_sys_rst || (wr_access &&
      ((i_apb.paddr == ADDR_TICK_COUNT) || (i_apb.paddr == ADDR_TIMER_CONTROL))); // R11

   always_comb begin
      if (prescale_select == PRE_DIV1) begin // R15
         pre_last = 4'h0;
      end else if (prescale_select == PRE_DIV4) begin
         pre_last = PRE_LAST4;
      end else begin
         pre_last = PRE_LAST16;
      end
   end

   // ------------------------------------------------------------
   // Prescaler and postscaler
   // ------------------------------------------------------------
   pmt_div_counter #(
      .WIDTH(4)
   ) u_prescaler (
      .i_clk(i_clk),
      .i_clear(scaler_clear), // R11
      .i_step(instr_tick), // R1
      .i_last(pre_last), // R10
      .o_done(pre_done)
   );

   pmt_div_counter #(
      .WIDTH(4)
   ) u_postscaler (
      .i_clk(i_clk),
      .i_clear(scaler_clear),
      .i_step(pre_done && at_match), // R5
      .i_last(postscale_select), // R15
      .o_done(post_done)
   );

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.pready = 1'b0;
      st_next.pslverr = 1'b0;
      st_next.match_pulse = post_done;
      if (timer_on) begin
         st_next.instr_div = st_reg.instr_div + 2'h1;
      end
      if (pre_done) begin
         if (at_match) begin
            st_next.tick_count = 8'h00; // R4
         end else begin
            st_next.tick_count = st_reg.tick_count + 8'h01; // R2
         end
      end
      if (wr_access) begin
         st_next.pready = 1'b1;
         if (i_apb.paddr == ADDR_TICK_COUNT) begin
            st_next.tick_count = i_apb.pwdata[7:0]; // R7
         end else if (i_apb.paddr == ADDR_MATCH_PERIOD) begin
            st_next.match_period = i_apb.pwdata[7:0]; // R7
         end else if (i_apb.paddr == ADDR_TIMER_CONTROL) begin
            st_next.timer_control = i_apb.pwdata[6:0]; // R12
         end else if (i_apb.paddr == ADDR_FLAG) begin
            st_next.match_flag = i_apb.pwdata[FLAG_MATCH_BIT];
         end else if (i_apb.paddr == ADDR_ENABLE) begin
            st_next.match_irq_enable = i_apb.pwdata[EN_MATCH_BIT];
         end else if (i_apb.paddr == ADDR_GLOBAL) begin
            st_next.periph_irq_enable = i_apb.pwdata[GLB_PERIPH_BIT];
         end else begin
            st_next.pslverr = 1'b1;
         end
      end
      if (rd_access) begin
         st_next.pready = 1'b1;
         st_next.prdata = 32'h0000_0000;
         if (i_apb.paddr == ADDR_TICK_COUNT) begin
            st_next.prdata[7:0] = st_reg.tick_count;
         end else if (i_apb.paddr == ADDR_MATCH_PERIOD) begin
            st_next.prdata[7:0] = st_reg.match_period;
         end else if (i_apb.paddr == ADDR_TIMER_CONTROL) begin
            st_next.prdata[6:0] = st_reg.timer_control;
         end else if (i_apb.paddr == ADDR_FLAG) begin
            st_next.prdata[FLAG_MATCH_BIT] = st_reg.match_flag;
            st_next.match_flag = 1'b0;
         end else if (i_apb.paddr == ADDR_ENABLE) begin
            st_next.prdata[EN_MATCH_BIT] = st_reg.match_irq_enable;
         end else if (i_apb.paddr == ADDR_GLOBAL) begin
            st_next.prdata[GLB_PERIPH_BIT] = st_reg.periph_irq_enable;
         end else begin
            st_next.pslverr = 1'b1;
         end
      end
      // Hardware set wins over any clear in the same cycle
      if (post_done) begin
         st_next.match_flag = 1'b1; // R6 R16
      end
      if (scaler_clear && !i_sys_rst) begin
         st_next.instr_div = 2'h0;
      end
      st_next.irq = st_next.match_flag && st_next.match_irq_enable
         && st_next.periph_irq_enable; // R13 R14
      if (i_sys_rst) begin
         st_next = '0;
         st_next.tick_count = TICK_RESET; // R8
         st_next.match_period = PERIOD_RESET; // R8
         st_next.timer_control = CTL_RESET;
      end
   end

   always_ff @(posedge i_clk) begin
      st_reg <= st_next;
   end

   assign o_apb.prdata = st_reg.prdata;
   assign o_apb.pready = st_reg.pready;
   assign o_apb.pslverr = st_reg.pslverr;
   assign o_irq = st_reg.irq;
   assign o_match_pulse = st_reg.match_pulse;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_reset_values;
      @(posedge i_clk) $past(i_sys_rst) |->
         (st_reg.tick_count == 8'h00) && (st_reg.match_period == 8'hff);
   endproperty
   a_reset_values: assert property (p_reset_values) else $error("reset values wrong"); // R8

   property p_wrap;
      @(posedge i_clk) disable iff (i_sys_rst)
         pre_done && at_match && !wr_access |=> st_reg.tick_count == 8'h00;
   endproperty
   a_wrap: assert property (p_wrap) else $error("count did not wrap on match"); // R4

   property p_inc;
      @(posedge i_clk) disable iff (i_sys_rst)
         pre_done && !at_match && !wr_access |=>
         st_reg.tick_count == $past(st_reg.tick_count) + 8'h01;
   endproperty
   a_inc: assert property (p_inc) else $error("count did not increment"); // R2

   property p_stopped;
      @(posedge i_clk) disable iff (i_sys_rst)
         !timer_on && !wr_access |=> $stable(st_reg.tick_count);
   endproperty
   a_stopped: assert property (p_stopped) else $error("count moved while off"); // R9

   property p_ctl_keeps_count;
      @(posedge i_clk) disable iff (i_sys_rst)
         wr_access && i_apb.paddr == ADDR_TIMER_CONTROL |=> $stable(st_reg.tick_count);
   endproperty
   a_ctl_keeps_count: assert property (p_ctl_keeps_count) else $error("ctl write moved count"); // R12

   property p_div1_rate;
      @(posedge i_clk) disable iff (i_sys_rst)
         instr_tick && prescale_select == PRE_DIV1 && !scaler_clear |-> pre_done;
   endproperty
   a_div1_rate: assert property (p_div1_rate) else $error("prescale 1 missed"); // R1

   property p_flag_set;
      @(posedge i_clk) disable iff (i_sys_rst) post_done |=> st_reg.match_flag;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set"); // R6

   property p_irq_gate;
      @(posedge i_clk) disable iff (i_sys_rst)
         st_reg.irq == (st_reg.match_flag && st_reg.match_irq_enable && st_reg.periph_irq_enable);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq not gated"); // R13

   property p_irq_global;
      @(posedge i_clk) disable iff (i_sys_rst)
         !st_reg.periph_irq_enable |-> !st_reg.irq;
   endproperty
   a_irq_global: assert property (p_irq_global) else $error("irq without global enable"); // R14

   property p_flag_hold;
      @(posedge i_clk) disable iff (i_sys_rst)
         st_reg.match_flag && !wr_access && !rd_access |=> st_reg.match_flag;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag dropped"); // R16

   property p_scaler_clear;
      @(posedge i_clk) disable iff (i_sys_rst)
         wr_access && i_apb.paddr == ADDR_TICK_COUNT |=> !pre_done[*3];
   endproperty
   a_scaler_clear: assert property (p_scaler_clear) else $error("prescaler not cleared"); // R11

   property p_ctl_clear;
      @(posedge i_clk) disable iff (i_sys_rst)
         wr_access && i_apb.paddr == ADDR_TIMER_CONTROL |=> !pre_done[*3];
   endproperty
   a_ctl_clear: assert property (p_ctl_clear) else $error("ctl write kept prescaler"); // R11

   property p_tick_write;
      @(posedge i_clk) disable iff (i_sys_rst)
         wr_access && i_apb.paddr == ADDR_TICK_COUNT |=>
         st_reg.tick_count == $past(i_apb.pwdata[7:0]);
   endproperty
   a_tick_write: assert property (p_tick_write) else $error("count write lost"); // R7

   property p_period_write;
      @(posedge i_clk) disable iff (i_sys_rst)
         wr_access && i_apb.paddr == ADDR_MATCH_PERIOD |=>
         st_reg.match_period == $past(i_apb.pwdata[7:0]);
   endproperty
   a_period_write: assert property (p_period_write) else $error("period write lost"); // R7

   property p_reset_ctl;
      @(posedge i_clk) $past(i_sys_rst) |->
         (st_reg.timer_control == CTL_RESET) && !st_reg.irq && !st_reg.pready;
   endproperty
   a_reset_ctl: assert property (p_reset_ctl) else $error("control not reset"); // R8

   property p_flag_read_clear;
      @(posedge i_clk) disable iff (i_sys_rst)
         rd_access && i_apb.paddr == ADDR_FLAG && !post_done |=> !st_reg.match_flag;
   endproperty
   a_flag_read_clear: assert property (p_flag_read_clear) else $error("flag not cleared"); // R16

   property p_pready_pulse;
      @(posedge i_clk) disable iff (i_sys_rst)
         st_reg.pready |=> !st_reg.pready;
   endproperty
   a_pready_pulse: assert property (p_pready_pulse) else $error("pready held too long");

   property p_slverr_ready;
      @(posedge i_clk) disable iff (i_sys_rst)
         st_reg.pslverr |-> st_reg.pready;
   endproperty
   a_slverr_ready: assert property (p_slverr_ready) else $error("pslverr without pready");
endmodule
`default_nettype wire

// ==== tb/periodic_match_timer_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module periodic_match_timer_tb;
   import pmt_pkg::*;
   logic i_clk;
   logic i_sys_rst;
   pmt_apb_req_type req;
   pmt_apb_rsp_type rsp;
   logic irq;
   logic mpulse;
   int mismatches;
   int check_count;
   logic [31:0] rd;
   logic err;
   int c;
   int pre_t[6] = '{0, 1, 2, 3, 0, 0};
   int post_t[6] = '{0, 0, 0, 0, 2, 15};
   int exp_t[6] = '{16, 64, 256, 256, 48, 256};

   pmt_timer DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_apb(req), .o_apb(rsp),
      .o_irq(irq), .o_match_pulse(mpulse));

   // ------------------------------------------------------------
   // Clock and watchdog
   // ------------------------------------------------------------
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end

   initial begin
      repeat (20000) @(posedge i_clk);
      mismatches++;
      print_verdict();
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic print_verdict();
      if (mismatches == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      req.psel <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite <= wr;
      req.paddr <= a;
      req.pwdata <= d;
      @(posedge i_clk);
      req.penable <= 1'b1;
      do @(posedge i_clk); while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(name, exp, rd);
   endtask

   // Clocks from one match pulse to the next
   task automatic gap(output int cnt);
      cnt = 0;
      do begin
         @(posedge i_clk);
         cnt++;
      end while (mpulse !== 1'b1 && cnt < 2000);
      cnt = 0;
      do begin
         @(posedge i_clk);
         cnt++;
      end while (mpulse !== 1'b1 && cnt < 2000);
   endtask

   task automatic do_reset();
      @(posedge i_clk);
      i_sys_rst <= 1'b1;
      repeat (4) @(posedge i_clk);
      i_sys_rst <= 1'b0;
   endtask

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      mismatches = 0;
      check_count = 0;
      req = '0;
      i_sys_rst = 1'b1;
      repeat (4) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      rdchk("tick_count reset", ADDR_TICK_COUNT, 32'h00);
      rdchk("match_period reset", ADDR_MATCH_PERIOD, 32'hff);
      rdchk("timer_control reset", ADDR_TIMER_CONTROL, 32'h00);
      wr(ADDR_MATCH_PERIOD, 32'ha5);
      rdchk("match_period rw", ADDR_MATCH_PERIOD, 32'ha5);
      wr(ADDR_TICK_COUNT, 32'h5a);
      rdchk("tick_count rw", ADDR_TICK_COUNT, 32'h5a);
      apb(1'b0, 8'h18, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
      wr(ADDR_MATCH_PERIOD, 32'h03);
      for (int i = 0; i < 6; i++) begin
         wr(ADDR_TIMER_CONTROL, 32'(post_t[i] * 8 + 4 + pre_t[i]));
         gap(c);
         chk("match interval", 32'(exp_t[i]), 32'(c));
      end
      wr(ADDR_TIMER_CONTROL, 32'h04);
      apb(1'b0, ADDR_FLAG, 32'h0);
      gap(c);
      wr(ADDR_TIMER_CONTROL, 32'h00);
      rdchk("flag after two matches", ADDR_FLAG, 32'h02);
      rdchk("flag after read", ADDR_FLAG, 32'h00);
      wr(ADDR_ENABLE, 32'h02);
      wr(ADDR_TIMER_CONTROL, 32'h04);
      gap(c);
      repeat (3) @(posedge i_clk);
      chk("irq without global", 32'h0, {31'h0, irq});
      wr(ADDR_GLOBAL, 32'h40);
      repeat (3) @(posedge i_clk);
      chk("irq enabled", 32'h1, {31'h0, irq});
      wr(ADDR_ENABLE, 32'h00);
      repeat (3) @(posedge i_clk);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(ADDR_ENABLE, 32'h02);
      wr(ADDR_TIMER_CONTROL, 32'h00);
      apb(1'b0, ADDR_FLAG, 32'h0);
      repeat (3) @(posedge i_clk);
      chk("irq after clear", 32'h0, {31'h0, irq});
      wr(ADDR_TICK_COUNT, 32'h07);
      wr(ADDR_TIMER_CONTROL, 32'h00);
      repeat (50) @(posedge i_clk);
      rdchk("tick held", ADDR_TICK_COUNT, 32'h07);
      do_reset();
      rdchk("tick_count second reset", ADDR_TICK_COUNT, 32'h00);
      rdchk("match_period second reset", ADDR_MATCH_PERIOD, 32'hff);
      print_verdict();
   end
endmodule
`default_nettype wire
